//--- external_bus_pin_mux.sv
// Pin multiplexer sharing the external bus between memory controllers.
`timescale 1ns/1ps
`default_nettype none
module external_bus_pin_mux (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Controller side
	input wire pin_mux_pkg::static_bus_t staticBus,
	input wire pin_mux_pkg::sdram_bus_t sdramBus,
	input wire pin_mux_pkg::cs_assign_t csAssign,
	output logic [pin_mux_pkg::DATA_W-1:0] dataToCtrl,
	output logic waitSyncN,
	output logic linkClockRise,
	// Shared pins
	output pin_mux_pkg::pins_t pins,
	output logic sdramClockPin,
	output logic nandSelect,
	// Data pins
	input wire logic [pin_mux_pkg::DATA_W-1:0] dataPinIn,
	output logic [pin_mux_pkg::DATA_W-1:0] dataPinOut,
	output logic dataPinOe,
	// Pins from outside the clock domain
	input wire logic waitPinN,
	input wire logic linkClockIn
);
	import pin_mux_pkg::*;

	pins_t pins_d;
	card_mode_t cardMode;
	logic linkSync;
	logic linkPrev_q;
	logic nandSelect_d;

	// Input crossings
	sync2 #(.WIDTH(DATA_W), .INIT(DATA_IDLE)) u_dataSync (
		.clock(clock),
		.srst(srst),
		.asyncIn(dataPinIn),
		.syncOut(dataToCtrl)
	);

	sync2 #(.WIDTH(1), .INIT(1'b1)) u_waitSync (
		.clock(clock),
		.srst(srst),
		.asyncIn(waitPinN),
		.syncOut(waitSyncN)
	);

	sync2 #(.WIDTH(1), .INIT(1'b0)) u_linkSync (
		.clock(clock),
		.srst(srst),
		.asyncIn(linkClockIn),
		.syncOut(linkSync)
	);

	// Ownership
	wire sdramOwn = sdramBus.active & csAssign.cs1Sdram;
	wire nandSel = ~sdramOwn & csAssign.cs3Nand &
		~staticBus.csN[NAND_CS_IDX];
	wire card0Sel = csAssign.cs4Card & ~staticBus.csN[CARD0_CS_IDX];
	wire card1Sel = csAssign.cs5Card & ~staticBus.csN[CARD1_CS_IDX];
	// NAND outranks the slots so two owners never share strobes
	wire cardSel = ~sdramOwn & ~nandSel & (card0Sel | card1Sel);
	wire plainStatic = ~sdramOwn & ~nandSel & ~cardSel;

	card_mode_decode u_cardMode (
		.slotActive(cardSel),
		.modeBits(staticBus.transferAddr[CARD_MODE_LSB+2:CARD_MODE_LSB]),
		.mode(cardMode)
	);

	wire cardIdeMode = (cardMode == CARD_IDE) | (cardMode == CARD_IDE_ALT);
	wire cardIoMode = (cardMode == CARD_IO) | cardIdeMode;

	// Static address shift by width
	bus_width_t width;
	assign width = staticBus.width;
	wire halfShift = (width == WIDTH_2X8) | (width == WIDTH_16);
	wire wordShift = (width == WIDTH_4X8) | (width == WIDTH_2X16) |
		(width == WIDTH_32);
	wire beMode = (width == WIDTH_2X16) | (width == WIDTH_32);
	wire [ADDR_W-1:0] shiftedAddr = wordShift ?
		{staticBus.devAddr[ADDR_W-3:0], 2'b00} : halfShift ?
		{staticBus.devAddr[ADDR_W-2:0], 1'b0} : staticBus.devAddr;

	// Pins A0 and A1 double as strobes on wide arrangements
	wire staticA0 = (width == WIDTH_8) ? shiftedAddr[0] :
		((width == WIDTH_16) | beMode) ? staticBus.byteSelN[0] :
		1'b1;
	wire staticA1 = (width == WIDTH_4X8) ? staticBus.writeN[2] :
		beMode ? staticBus.byteSelN[2] : shiftedAddr[1];
	wire staticLane1 = ((width == WIDTH_2X8) | (width == WIDTH_4X8)) ?
		staticBus.writeN[1] : ((width == WIDTH_16) | beMode) ?
		staticBus.byteSelN[1] : 1'b1;
	wire staticLane3 = (width == WIDTH_4X8) ? staticBus.writeN[3] :
		beMode ? staticBus.byteSelN[3] : 1'b1;
	wire [ADDR_W-1:0] staticAddr = {shiftedAddr[ADDR_W-1:2], staticA1,
		staticA0};

	// NAND latches ride on the address pins
	wire [ADDR_W-1:0] nandAddr = {staticAddr[ADDR_W-1:NAND_CLE_BIT+1],
		staticBus.transferAddr[NAND_CLE_BIT],
		staticBus.transferAddr[NAND_ALE_BIT],
		staticAddr[NAND_ALE_BIT-1:0]};

	// Card slot: A22 register select, A25 buffer direction
	wire cardDir = &staticBus.writeN;
	wire [ADDR_W-1:0] cardAddr = {cardDir,
		staticBus.transferAddr[CARD_DIR_BIT-1:0]};

	// SDRAM address layout
	wire [ADDR_W-1:0] sdramAddr = {8'h00, sdramBus.bank[1],
		sdramBus.bank[0], 1'b0, sdramBus.addr[12:11], 1'b0,
		sdramBus.addr[9], sdramBus.addr[8:0], sdramBus.maskN[2],
		sdramBus.maskN[0]};

	wire [ADDR_W-1:0] addrSel = sdramOwn ? sdramAddr : nandSel ? nandAddr :
		cardSel ? cardAddr : staticAddr;

	// Chip selects: select 1 leaves the static path when assigned to SDRAM
	wire [CS_COUNT-1:0] staticCs = sdramOwn ? CS_IDLE : (staticBus.csN |
		{4'h0, csAssign.cs1Sdram, 1'b0});
	wire [CS_COUNT-1:0] csSel = {staticCs[CS_COUNT-1:SDRAM_CS_IDX+1],
		staticCs[SDRAM_CS_IDX] & (sdramOwn ? sdramBus.selectN : 1'b1),
		staticCs[0]};

	wire staticIdle = sdramOwn | nandSel;
	// Card I/O cycles steer strobes to the I/O pins
	wire readSel = staticIdle | (cardSel & cardIdeMode) ? 1'b1 :
		staticBus.readN;
	wire lane0Sel = sdramOwn | nandSel | (cardSel & cardIoMode) ? 1'b1 :
		staticBus.writeN[0];
	wire lane1Sel = sdramOwn ? sdramBus.maskN[1] : nandSel ? 1'b1 :
		cardSel ? (cardIoMode ? staticBus.readN : 1'b1) :
		staticLane1;
	wire lane3Sel = sdramOwn ? sdramBus.maskN[3] : nandSel ? 1'b1 :
		cardSel ? (cardIoMode ? staticBus.writeN[0] : 1'b1) :
		staticLane3;

	wire slotCsN = ~cardSel;
	wire card1Sel_n = slotCsN | staticBus.byteSelN[0];
	wire card2Sel_n = slotCsN | staticBus.byteSelN[1];

	always_comb begin
		pins_d = PINS_IDLE;
		pins_d.addr = addrSel;
		pins_d.sdramAddr10Pin = sdramOwn & sdramBus.addr[10];
		pins_d.csN = csSel;
		pins_d.readStrobe = readSel;
		pins_d.lane0WriteStrobe = lane0Sel;
		pins_d.lane1WriteStrobe = lane1Sel;
		pins_d.lane3WriteStrobe = lane3Sel;
		pins_d.nandReadEnable = ~nandSel | staticBus.readN;
		pins_d.nandWriteEnable = ~nandSel | staticBus.writeN[0];
		pins_d.cardEnable1 = card1Sel_n;
		pins_d.cardEnable2 = card2Sel_n;
		pins_d.sdramRasN = ~sdramOwn | sdramBus.rasN;
		pins_d.sdramCasN = ~sdramOwn | sdramBus.casN;
		pins_d.sdramWeN = ~sdramOwn | sdramBus.weN;
		// Dedicated pin: stays with the controller so refresh state holds
		pins_d.sdramCke = sdramBus.cke;
	end

	assign nandSelect_d = ~nandSel;

	// Data lanes follow the owner; NAND uses the static data path
	wire [DATA_W-1:0] dataSel = sdramOwn ? sdramBus.dataOut :
		staticBus.dataOut;
	wire oeSel = sdramOwn ? sdramBus.dataOe : staticBus.dataOe;

	always_ff @(posedge clock) begin
		if (srst) begin
			pins <= PINS_IDLE;
			nandSelect <= 1'b1;
			dataPinOut <= DATA_IDLE;
			dataPinOe <= 1'b0;
		end else begin
			pins <= pins_d;
			nandSelect <= nandSelect_d;
			dataPinOut <= dataSel;
			dataPinOe <= oeSel;
		end
	end

	// Clock pin regenerated from the sampled link clock
	always_ff @(posedge clock) begin
		if (srst) begin
			linkPrev_q <= 1'b0;
			sdramClockPin <= 1'b0;
		end else begin
			linkPrev_q <= linkSync;
			sdramClockPin <= linkSync;
		end
	end

	assign linkClockRise = linkSync & ~linkPrev_q;

	property p_two_byte;
		@(posedge clock) disable iff (srst)
		plainStatic && width == WIDTH_2X8 |=>
			pins.lane0WriteStrobe == $past(staticBus.writeN[0]) &&
			pins.lane1WriteStrobe == $past(staticBus.writeN[1]);
	endproperty
	a_two_byte: assert property (p_two_byte)
		else $error("paired byte write strobes misrouted");

	property p_four_byte;
		@(posedge clock) disable iff (srst)
		plainStatic && width == WIDTH_4X8 |=>
			pins.addr[1] == $past(staticBus.writeN[2]) &&
			pins.lane3WriteStrobe == $past(staticBus.writeN[3]);
	endproperty
	a_four_byte: assert property (p_four_byte)
		else $error("upper lane write strobes misrouted");

	property p_low_half;
		@(posedge clock) disable iff (srst)
		plainStatic && width == WIDTH_2X16 |=>
			pins.addr[0] == $past(staticBus.byteSelN[0]) &&
			pins.lane1WriteStrobe == $past(staticBus.byteSelN[1]);
	endproperty
	a_low_half: assert property (p_low_half)
		else $error("lower half-word byte selects misrouted");

	property p_high_half;
		@(posedge clock) disable iff (srst)
		plainStatic && beMode ##1 1'b1 |->
			pins.addr[1] == $past(staticBus.byteSelN[2]) &&
			pins.lane3WriteStrobe == $past(staticBus.byteSelN[3]);
	endproperty
	a_high_half: assert property (p_high_half)
		else $error("upper half-word byte selects misrouted");

	property p_addr_shift;
		@(posedge clock) disable iff (srst)
		plainStatic && halfShift |=>
			pins.addr[ADDR_W-1:2] == $past(staticBus.devAddr[ADDR_W-2:1]);
	endproperty
	a_addr_shift: assert property (p_addr_shift)
		else $error("static address not shifted by one");

	property p_chip_select;
		@(posedge clock) disable iff (srst)
		!sdramOwn |=> pins.csN[0] == $past(staticBus.csN[0]) &&
			pins.readStrobe == $past(staticBus.readN | nandSel |
			(cardSel & cardIdeMode));
	endproperty
	a_chip_select: assert property (p_chip_select)
		else $error("static select or read strobe wrong");

	property p_sdram_pins;
		@(posedge clock) disable iff (srst)
		sdramOwn |=> pins.addr[10:2] == $past(sdramBus.addr[8:0]) &&
			pins.sdramAddr10Pin == $past(sdramBus.addr[10]) &&
			pins.addr[BA1_BIT:BA0_BIT] == $past(sdramBus.bank) &&
			pins.csN[SDRAM_CS_IDX] == $past(sdramBus.selectN);
	endproperty
	a_sdram_pins: assert property (p_sdram_pins)
		else $error("sdram address or select misrouted");

	property p_nand;
		@(posedge clock) disable iff (srst)
		nandSel |=> !nandSelect && pins.addr[NAND_CLE_BIT] ==
			$past(staticBus.transferAddr[NAND_CLE_BIT]) &&
			pins.lane0WriteStrobe &&
			pins.cardEnable1 && pins.cardEnable2;
	endproperty
	a_nand: assert property (p_nand)
		else $error("nand latch or select wrong");

	property p_card_io;
		@(posedge clock) disable iff (srst)
		cardSel && cardIoMode |=>
			pins.lane1WriteStrobe == $past(staticBus.readN) &&
			pins.addr[CARD_DIR_BIT] == $past(cardDir);
	endproperty
	a_card_io: assert property (p_card_io)
		else $error("card io read or direction wrong");

	property p_card_enable;
		@(posedge clock) disable iff (srst)
		cardSel |=> pins.cardEnable1 == $past(staticBus.byteSelN[0]) &&
			pins.cardEnable2 == $past(staticBus.byteSelN[1]);
	endproperty
	a_card_enable: assert property (p_card_enable)
		else $error("card enables do not follow byte selects");

	property p_owner;
		@(posedge clock) disable iff (srst)
		sdramOwn[*2] |-> pins.readStrobe && pins.nandReadEnable &&
			pins.cardEnable1 && pins.cardEnable2;
	endproperty
	a_owner: assert property (p_owner)
		else $error("static strobes active during sdram access");

	c_sdram: cover property (@(posedge clock) disable iff (srst)
		sdramOwn ##1 plainStatic);
	c_nand: cover property (@(posedge clock) disable iff (srst) nandSel);
	c_ide: cover property (@(posedge clock) disable iff (srst)
		cardSel && cardIdeMode);
	c_word: cover property (@(posedge clock) disable iff (srst)
		plainStatic && width == WIDTH_32);

endmodule : external_bus_pin_mux
`default_nettype wire

//--- pin_mux_pkg.sv
// Constants, types and pin layouts of the external bus pin multiplexer.
// Behaviour
// - Two 8-bit parts: lane-0 pin writes low byte, lane-1 pin writes high.
// - Four 8-bit parts: four write strobes, each one for its own byte lane.
// - Two 16-bit parts: byte selects 0 and 1 qualify the lower half-word.
// - Two 16-bit parts: byte select 2 on address-1, select 3 upper half.
// - 32-bit part: address-0, address-1, lane-1, lane-3 carry enables 0,2,1,3.
// - Static address shifts by width: device A0 on pin A0, A1 or A2.
// - Six chip selects serve any static part; read is OE, lane-0 is WE.
// - SDRAM row/column, A10, A11-A12 and bank selects on their fixed pins.
// - SDRAM masks on address-0, lane-1, address-1, lane-3; select 1 is SDRAM.
// - NAND: data pins carry address/data, latch enables on A21 and A22.
// - Card slot: register select A22, direction A25, enables and I/O strobes.
// - Assignment bits give select 1 to SDRAM, 3 to NAND, 4 and 5 to slots.
// - Card address bits 23:21 choose attribute, common, I/O or IDE modes.
`default_nettype none
package pin_mux_pkg;

	localparam int ADDR_W = 26;
	localparam int DATA_W = 32;
	localparam int SD_ADDR_W = 13;
	localparam int CS_COUNT = 6;
	localparam int LANES = 4;

	localparam int BA0_BIT = 16;
	localparam int BA1_BIT = 17;
	localparam int NAND_ALE_BIT = 21;
	localparam int NAND_CLE_BIT = 22;
	localparam int CARD_REG_BIT = 22;
	localparam int CARD_DIR_BIT = 25;
	localparam int CARD_MODE_LSB = 21;

	localparam int SDRAM_CS_IDX = 1;
	localparam int NAND_CS_IDX = 3;
	localparam int CARD0_CS_IDX = 4;
	localparam int CARD1_CS_IDX = 5;

	localparam logic [2:0] CARD_CODE_ATTR = 3'h0;
	localparam logic [2:0] CARD_CODE_COMMON = 3'h2;
	localparam logic [2:0] CARD_CODE_IO = 3'h4;
	localparam logic [2:0] CARD_CODE_IDE = 3'h6;
	localparam logic [2:0] CARD_CODE_IDE_ALT = 3'h7;

	localparam logic [CS_COUNT-1:0] CS_IDLE = 6'h3F;
	localparam logic [ADDR_W-1:0] ADDR_IDLE = 26'h0000000;
	localparam logic [DATA_W-1:0] DATA_IDLE = 32'h00000000;

	typedef enum logic [5:0] {
		WIDTH_8 = 6'b000001,
		WIDTH_2X8 = 6'b000010,
		WIDTH_16 = 6'b000100,
		WIDTH_4X8 = 6'b001000,
		WIDTH_2X16 = 6'b010000,
		WIDTH_32 = 6'b100000
	} bus_width_t;

	typedef enum logic [5:0] {
		CARD_NONE = 6'b000001,
		CARD_ATTR = 6'b000010,
		CARD_COMMON = 6'b000100,
		CARD_IO = 6'b001000,
		CARD_IDE = 6'b010000,
		CARD_IDE_ALT = 6'b100000
	} card_mode_t;

	typedef struct packed {
		bus_width_t width;
		logic [ADDR_W-1:0] devAddr;
		logic [ADDR_W-1:0] transferAddr;
		logic [CS_COUNT-1:0] csN;
		logic readN;
		logic [LANES-1:0] writeN;
		logic [LANES-1:0] byteSelN;
		logic [DATA_W-1:0] dataOut;
		logic dataOe;
	} static_bus_t;

	typedef struct packed {
		logic active;
		logic [SD_ADDR_W-1:0] addr;
		logic [1:0] bank;
		logic [LANES-1:0] maskN;
		logic selectN;
		logic rasN;
		logic casN;
		logic weN;
		logic cke;
		logic [DATA_W-1:0] dataOut;
		logic dataOe;
	} sdram_bus_t;

	typedef struct packed {
		logic cs1Sdram;
		logic cs3Nand;
		logic cs4Card;
		logic cs5Card;
	} cs_assign_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic sdramAddr10Pin;
		logic [CS_COUNT-1:0] csN;
		logic readStrobe;
		logic lane0WriteStrobe;
		logic lane1WriteStrobe;
		logic lane3WriteStrobe;
		logic nandReadEnable;
		logic nandWriteEnable;
		logic cardEnable1;
		logic cardEnable2;
		logic sdramRasN;
		logic sdramCasN;
		logic sdramWeN;
		logic sdramCke;
	} pins_t;

	localparam pins_t PINS_IDLE = '{addr: ADDR_IDLE, sdramAddr10Pin: 1'b0,
		csN: CS_IDLE, readStrobe: 1'b1, lane0WriteStrobe: 1'b1,
		lane1WriteStrobe: 1'b1, lane3WriteStrobe: 1'b1,
		nandReadEnable: 1'b1, nandWriteEnable: 1'b1, cardEnable1: 1'b1,
		cardEnable2: 1'b1, sdramRasN: 1'b1, sdramCasN: 1'b1,
		sdramWeN: 1'b1, sdramCke: 1'b0};

endpackage : pin_mux_pkg
`default_nettype wire

//--- sync2.sv
// Two-flop synchroniser bank for inputs from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Asynchronous input and synchronised copy
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_q;

	if (WIDTH < 1) begin : g_check
		$error("sync2 needs WIDTH of at least one");
	end

	// First stage feeds only the second
	always_ff @(posedge clock) begin
		if (srst) begin
			stage1_q <= INIT;
			syncOut <= INIT;
		end else begin
			stage1_q <= asyncIn;
			syncOut <= stage1_q;
		end
	end
endmodule : sync2
`default_nettype wire

//--- card_mode_decode.sv
// Card slot access mode decode from transfer address bits.
`timescale 1ns/1ps
`default_nettype none
module card_mode_decode (
	// Slot access and mode bits
	input wire logic slotActive,
	input wire logic [2:0] modeBits,
	// Decoded mode
	output pin_mux_pkg::card_mode_t mode
);
	import pin_mux_pkg::*;

	// Unlisted codes fall back to no card function
	always_comb begin
		mode = CARD_NONE;
		if (slotActive) begin
			case (modeBits)
				CARD_CODE_ATTR: mode = CARD_ATTR;
				CARD_CODE_COMMON: mode = CARD_COMMON;
				CARD_CODE_IO: mode = CARD_IO;
				CARD_CODE_IDE: mode = CARD_IDE;
				CARD_CODE_IDE_ALT: mode = CARD_IDE_ALT;
				default: mode = CARD_NONE;
			endcase
		end
	end
endmodule : card_mode_decode
`default_nettype wire

//--- ext_mem_model.sv
// Behavioural external memories answering reads on the shared pins.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	// Clock
	input wire logic clock,
	// Pins from the multiplexer
	input wire pin_mux_pkg::pins_t pins,
	// Answer towards the multiplexer
	output logic [pin_mux_pkg::DATA_W-1:0] dataPinIn,
	output logic waitPinN
);
	import pin_mux_pkg::*;
	logic [DATA_W-1:0] lastQ;
	wire logic readSel;
	wire logic [DATA_W-1:0] fresh;
	// Output enable of static part or NAND read strobe
	assign readSel = !pins.readStrobe || !pins.nandReadEnable;
	assign fresh = {pins.addr[15:0], ~pins.addr[15:0]};
	// Released bus shows the inverse so a stale value never passes
	assign dataPinIn = readSel ? fresh : ~lastQ;
	// Slow answer on reads with address pin 3 set
	assign waitPinN = !(readSel && pins.addr[3]);
	always_ff @(posedge clock) begin
		if (readSel)
			lastQ <= fresh;
	end
endmodule : ext_mem_model
`default_nettype wire

//--- external_bus_pin_mux_tb.sv
// Self-checking bench of the external bus pin multiplexer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin nTests++; if ((gt) !== (ex)) begin \
	errorCnt++; $display("unexpected %s exp %0h got %0h", nm, ex, gt); \
	end end
module external_bus_pin_mux_tb;
	import pin_mux_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic linkClockIn = 1'b0;
	static_bus_t sIn = '0;
	sdram_bus_t dIn = '0;
	cs_assign_t aIn = '0;
	pins_t pins;
	logic [DATA_W-1:0] dataToCtrl, dataPinIn, dataPinOut;
	logic waitSyncN, linkClockRise, sdramClockPin, nandSelect;
	logic dataPinOe, waitPinN;
	int errorCnt = 0;
	int nTests = 0;
	logic [31:0] lfsr = 32'h00000006;
	bus_width_t widths [6] = '{WIDTH_8, WIDTH_2X8, WIDTH_16, WIDTH_4X8,
		WIDTH_2X16, WIDTH_32};

	always #50 clock = ~clock;
	always #400 linkClockIn = ~linkClockIn;

	external_bus_pin_mux uut (.clock(clock), .srst(srst), .staticBus(sIn),
		.sdramBus(dIn), .csAssign(aIn), .dataToCtrl(dataToCtrl),
		.waitSyncN(waitSyncN), .linkClockRise(linkClockRise), .pins(pins),
		.sdramClockPin(sdramClockPin), .nandSelect(nandSelect),
		.dataPinIn(dataPinIn), .dataPinOut(dataPinOut),
		.dataPinOe(dataPinOe), .waitPinN(waitPinN),
		.linkClockIn(linkClockIn));
	ext_mem_model mem (.clock(clock), .pins(pins), .dataPinIn(dataPinIn),
		.waitPinN(waitPinN));

	function automatic pins_t expPins(static_bus_t s, sdram_bus_t d,
		cs_assign_t a);
		pins_t p;
		logic io;
		p = PINS_IDLE;
		p.sdramCke = d.cke;
		if (d.active && a.cs1Sdram) begin
			p.addr[11:2] = d.addr[9:0];
			p.sdramAddr10Pin = d.addr[10];
			p.addr[14:13] = d.addr[12:11];
			p.addr[17:16] = d.bank;
			p.addr[1:0] = {d.maskN[2], d.maskN[0]};
			p.lane1WriteStrobe = d.maskN[1];
			p.lane3WriteStrobe = d.maskN[3];
			p.csN[1] = d.selectN;
			{p.sdramRasN, p.sdramCasN, p.sdramWeN, p.sdramCke} =
				{d.rasN, d.casN, d.weN, d.cke};
			return p;
		end
		p.csN = s.csN;
		if (a.cs1Sdram)
			p.csN[1] = 1'b1;
		p.readStrobe = s.readN;
		p.lane0WriteStrobe = s.writeN[0];
		case (s.width)
			WIDTH_8: p.addr = s.devAddr;
			WIDTH_2X8, WIDTH_16: p.addr = {s.devAddr[24:0], 1'b1};
			default: p.addr = {s.devAddr[23:0], 2'b11};
		endcase
		if (s.width inside {WIDTH_16, WIDTH_2X16, WIDTH_32})
			{p.lane1WriteStrobe, p.addr[0]} = s.byteSelN[1:0];
		if (s.width inside {WIDTH_2X16, WIDTH_32})
			{p.lane3WriteStrobe, p.addr[1]} = s.byteSelN[3:2];
		if (s.width inside {WIDTH_2X8, WIDTH_4X8})
			p.lane1WriteStrobe = s.writeN[1];
		if (s.width == WIDTH_4X8)
			{p.lane3WriteStrobe, p.addr[1]} = s.writeN[3:2];
		if (a.cs3Nand && !s.csN[3]) begin
			p.addr[22:21] = s.transferAddr[22:21];
			{p.nandReadEnable, p.nandWriteEnable} = {s.readN, s.writeN[0]};
			{p.readStrobe, p.lane0WriteStrobe} = 2'b11;
			{p.lane1WriteStrobe, p.lane3WriteStrobe} = 2'b11;
			return p;
		end
		if (!((a.cs4Card && !s.csN[4]) || (a.cs5Card && !s.csN[5])))
			return p;
		io = s.transferAddr[23:21] inside {CARD_CODE_IO, CARD_CODE_IDE,
			CARD_CODE_IDE_ALT};
		p.addr = {&s.writeN, s.transferAddr[24:0]};
		{p.cardEnable2, p.cardEnable1} = s.byteSelN[1:0];
		p.lane1WriteStrobe = io ? s.readN : 1'b1;
		p.lane3WriteStrobe = io ? s.writeN[0] : 1'b1;
		p.lane0WriteStrobe = io ? 1'b1 : s.writeN[0];
		if (s.transferAddr[23:22] == 2'b11)
			p.readStrobe = 1'b1;
		return p;
	endfunction : expPins

	task automatic rnd(output logic [31:0] r);
		lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'hA3000000 : lfsr >> 1;
		r = lfsr;
	endtask : rnd

	task automatic randIn();
		logic [31:0] r [6];
		foreach (r[i])
			rnd(r[i]);
		sIn = static_bus_t'({r[1], r[2], r[3], r[4][9:0]});
		sIn.width = widths[r[5][2:0] % 6];
		dIn = sdram_bus_t'({r[5][31:6], r[0]});
		aIn = cs_assign_t'(r[1][7:4]);
	endtask : randIn

	task automatic check();
		logic sd;
		@(posedge clock);
		@(negedge clock);
		sd = dIn.active && aIn.cs1Sdram;
		`CHK("pins", expPins(sIn, dIn, aIn), pins)
		`CHK("dataOe", sd ? dIn.dataOe : sIn.dataOe, dataPinOe)
		if (dataPinOe === 1'b1)
			`CHK("dataOut", sd ? dIn.dataOut : sIn.dataOut, dataPinOut)
		`CHK("nandSel", !(!sd && aIn.cs3Nand && !sIn.csN[3]), nandSelect)
	endtask : check

	task automatic testDone();
		$display("checks %0d mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : testDone

	initial begin
		int kind;
		int rises;
		logic prevClk;
		pins_t e;
		repeat (20) @(negedge clock);
		`CHK("rstPins", PINS_IDLE, pins)
		srst = 1'b0;
		$display("test reset done");
		// Every width against every card code, NAND, SDRAM and plain
		for (int k = 0; k < 72; k++) begin
			randIn();
			kind = k / 6;
			sIn.width = widths[k % 6];
			aIn = cs_assign_t'(kind < 8 ? 4'h2 : kind == 8 ? 4'h4 :
				kind == 9 ? 4'h8 : kind == 11 ? 4'h1 : 4'h0);
			dIn.active = (kind == 9);
			sIn.csN[5:3] = {kind != 11, kind >= 8, kind != 8};
			sIn.transferAddr[23:21] = kind[2:0];
			check();
		end
		$display("test corners done");
		repeat (300) begin
			randIn();
			check();
		end
		$display("test random done");
		randIn();
		aIn = cs_assign_t'(4'h0);
		dIn.active = 1'b0;
		sIn.readN = 1'b0;
		sIn.width = WIDTH_32;
		repeat (4)
			check();
		e = expPins(sIn, dIn, aIn);
		`CHK("rdData", {e.addr[15:0], ~e.addr[15:0]}, dataToCtrl)
		`CHK("wait", !e.addr[3], waitSyncN)
		$display("test sync done");
		// Link clock period is exactly eight system cycles
		rises = 0;
		kind = 0;
		prevClk = sdramClockPin;
		repeat (80) begin
			@(negedge clock);
			rises += (linkClockRise === 1'b1);
			kind += (sdramClockPin === 1'b1 && prevClk === 1'b0);
			prevClk = sdramClockPin;
		end
		`CHK("linkRises", 10, rises)
		`CHK("sdClkRises", 10, kind)
		$display("test link clock done");
		testDone();
	end
endmodule : external_bus_pin_mux_tb
`default_nettype wire
